// [bench/partition_resource_config_props.sv]
// Port-level assertions for the partition configuration bank
`timescale 1ns/1ps
module part_cfg_props
  import part_cfg_pkg::*;
#(parameter int NUM_ENTRIES = 16) (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // Register bus
  input wire apb_req_t                apbReq,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  // Lookup port
  input wire logic                    lookupNonsecure,
  input wire logic [SEL_WIDTH-1:0]    lookupPartition,
  input wire logic                    lookupStrideEn,
  input wire logic [STRIDE_WIDTH-1:0] lookupStride,
  input wire logic [MAP_WIDTH-1:0]    lookupPortionMap,
  // Selector copies
  input wire logic [SEL_WIDTH-1:0]    secureSelect,
  input wire logic [SEL_WIDTH-1:0]    nonsecureSelect
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic        rdDone = pready && !apbReq.pwrite; // Read answered
  wire logic [15:0] adr    = apbReq.paddr;            // Held address
  // First access cycle, before the wait state ends
  sequence accStart;
    apbReq.psel && apbReq.penable && !pready;
  endsequence
  a_ready_one_wait: assert property (accStart |=> pready ##1 !pready)
    else $error("ready timing wrong");
  a_flag_reads_zero: assert property (rdDone && adr == PART_SELECT_OFF
    |-> prdata[31:16] == 16'h0000) else $error("flag not zero");
  a_sel_read_copy: assert property (rdDone && adr == PART_SELECT_OFF
    |-> prdata[15:0] == (apbReq.pprot1 ? nonsecureSelect : secureSelect))
    else $error("wrong selector copy");
  a_sel_write_take: assert property (accStart and apbReq.pwrite &&
    adr == PART_SELECT_OFF && !apbReq.pprot1 |=> $stable(nonsecureSelect)
    && secureSelect == $past(apbReq.pwdata[15:0])) else $error("sel lost");
  a_stride_resv_zero: assert property (rdDone && adr == BW_STRIDE_OFF
    |-> prdata[30:6] == 25'h0) else $error("stride reserved set");
  a_map_resv_zero: assert property (rdDone && adr == PORTION_MAP_OFF
    |-> prdata[31:8] == 24'h0) else $error("map reserved set");
  a_width_reads_eight: assert property (rdDone
    && adr == PORTION_WIDTH_OFF |-> prdata == {16'h0000, MAP_WD_VALUE})
    else $error("width wrong");
  a_lookup_range: assert property (lookupPartition >= NUM_ENTRIES
    |=> lookupPortionMap == 8'hff && !lookupStrideEn)
    else $error("range lookup wrong");
endmodule // part_cfg_props

bind partition_resource_config part_cfg_props #(.NUM_ENTRIES(NUM_ENTRIES))
  u_props (.mclk(mclk), .rst_n(rst_n), .apbReq(apbReq), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .lookupNonsecure(lookupNonsecure),
  .lookupPartition(lookupPartition), .lookupStrideEn(lookupStrideEn),
  .lookupStride(lookupStride), .lookupPortionMap(lookupPortionMap),
  .secureSelect(secureSelect), .nonsecureSelect(nonsecureSelect));

// [bench/testbench.sv]
// Random and corner-case bench for the partition configuration bank
`timescale 1ns/1ps
module testbench;
  import part_cfg_pkg::*;
  logic        mclk, rst_n, pready, pslverr, lkNs, lkEn, apbErr;
  apb_req_t    req;                   // Bus request towards the bank
  logic [31:0] prdata, rdData, s, d;  // Bus data and random state
  logic [15:0] lkPart, secSel, nsSel, selM[2];
  logic [5:0]  lkStride;
  logic [7:0]  lkMap;
  logic [31:0] strideM[2][16], mapM[2][16]; // Reference copy of table
  int          miscompares, checks, cycles;

  partition_resource_config #(.NUM_ENTRIES(16)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .apbReq(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .lookupNonsecure(lkNs),
    .lookupPartition(lkPart), .lookupStrideEn(lkEn),
    .lookupStride(lkStride), .lookupPortionMap(lkMap),
    .secureSelect(secSel), .nonsecureSelect(nsSel));

  // Free-running 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Repeatable xorshift stream
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Expected read data; out-of-range entries read zero
  function automatic logic [31:0] expRd(logic [15:0] a, logic ns);
    logic [15:0] p = selM[ns];
    case (a)
      PORTION_WIDTH_OFF: return {16'h0000, MAP_WD_VALUE};
      PART_SELECT_OFF:   return {16'h0000, p};
      BW_STRIDE_OFF:     return p < 16 ? strideM[ns][p] : 32'h0;
      PORTION_MAP_OFF:   return p < 16 ? mapM[ns][p] : 32'h0;
      default:           return 32'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] wd, input logic ns);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, wd, ns};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdData = prdata;
    apbErr = pslverr;
    req <= '0;
  endtask

  // Read and compare data and the error flag
  task automatic rdchk(input logic [15:0] a, input logic ns);
    apb(1'b0, a, 32'h0, ns);
    chk(rdData, expRd(a, ns));
    chk({31'h0, apbErr}, {31'h0, !(a inside {PORTION_WIDTH_OFF,
      PART_SELECT_OFF, BW_STRIDE_OFF, PORTION_MAP_OFF})});
  endtask

  // Write and mirror the effect in the reference copy
  task automatic wr(input logic [15:0] a, input logic ns,
                    input logic [31:0] v);
    apb(1'b1, a, v, ns);
    if (a == PART_SELECT_OFF) selM[ns] = v[15:0];
    if (a == BW_STRIDE_OFF && selM[ns] < 16)
      strideM[ns][selM[ns]] = v & 32'h8000003f;
    if (a == PORTION_MAP_OFF && selM[ns] < 16)
      mapM[ns][selM[ns]] = v & 32'h000000ff;
  endtask

  // Lookup result arrives one edge after the request
  task automatic lookChk(input logic ns, input logic [15:0] p);
    lkNs <= ns;
    lkPart <= p;
    repeat (2) @(posedge mclk);
    chk({lkEn, lkStride, lkMap}, p < 16 ? {strideM[ns][p][31],
      strideM[ns][p][5:0], mapM[ns][p][7:0]} : 15'h00ff);
  endtask

  task automatic final_report();
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    lkNs = 1'b0;
    lkPart = 16'h0000;
    s = 32'd49413;
    selM = '{16'h0000, 16'h0000};
    foreach (strideM[n, e]) begin
      strideM[n][e] = 32'h0;
      mapM[n][e] = 32'hff;
    end
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, read-only width, unmapped offset
    for (int n = 0; n < 2; n++) begin
      rdchk(PART_SELECT_OFF, n[0]);
      rdchk(BW_STRIDE_OFF, n[0]);
      rdchk(PORTION_MAP_OFF, n[0]);
      wr(PORTION_WIDTH_OFF, n[0], 32'hffffffff);
      rdchk(PORTION_WIDTH_OFF, n[0]);
      rdchk(16'h0200, n[0]);
    end
    // Random selectors, half out of range, flag bit always set
    for (int i = 0; i < 150; i++) begin
      d = xs();
      wr(PART_SELECT_OFF, d[31], {d[30:16], 1'b1, 11'h0, d[4:0]});
      rdchk(PART_SELECT_OFF, d[31]);
      wr(BW_STRIDE_OFF, d[31], xs());
      wr(PORTION_MAP_OFF, d[31], xs());
      rdchk(BW_STRIDE_OFF, d[31]);
      rdchk(PORTION_MAP_OFF, !d[31]);
      rdchk(BW_STRIDE_OFF, !d[31]);
      lookChk(d[5], {11'h0, d[10:6]});
    end
    final_report();
  end
endmodule // testbench

// [verilog/part_cfg_pkg.sv]
// Constants and types for the partition resource configuration bank
package part_cfg_pkg;

  // Register byte offsets
  localparam logic [15:0] PORTION_WIDTH_OFF = 16'h0030;
  localparam logic [15:0] PART_SELECT_OFF   = 16'h0100;
  localparam logic [15:0] BW_STRIDE_OFF     = 16'h0500;
  localparam logic [15:0] PORTION_MAP_OFF   = 16'h1000;

  // Field positions and widths
  localparam int SEL_WIDTH     = 16;
  localparam int INTERNAL_BIT  = 16;
  localparam int STRIDE_WIDTH  = 6;
  localparam int STRIDE_EN_BIT = 31;
  localparam int MAP_WIDTH     = 8;

  // Reset values
  localparam logic [SEL_WIDTH-1:0]    SEL_RESET    = 16'h0000;
  localparam logic                    EN_RESET     = 1'b0;
  localparam logic [STRIDE_WIDTH-1:0] STRIDE_RESET = 6'h00;
  localparam logic [MAP_WIDTH-1:0]    MAP_RESET    = 8'hff;
  localparam logic [15:0]             MAP_WD_VALUE = 16'h0008;

  // One stored partition entry
  typedef struct packed {
    logic                    strideEn;
    logic [STRIDE_WIDTH-1:0] strideMinusOne;
    logic [MAP_WIDTH-1:0]    portionMap;
  } part_entry_t;

  // APB request carried as one bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic        pprot1;
  } apb_req_t;

  // Decoded register target
  typedef enum logic [2:0] {
    REG_NONE, REG_WIDTH, REG_SELECT, REG_STRIDE, REG_MAP
  } reg_sel_t;

endpackage

// [verilog/partition_resource_config.sv]
// Partition resource configuration bank with APB register slave
`timescale 1ns/1ps
module partition_resource_config
  import part_cfg_pkg::*;
#(
  parameter int NUM_ENTRIES = 16
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // APB slave, pprot[1] high marks a nonsecure access
  input  wire apb_req_t                apbReq,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Lookup port for the cache allocation and bandwidth logic
  input  wire logic                    lookupNonsecure,
  input  wire logic [SEL_WIDTH-1:0]    lookupPartition,
  output logic                         lookupStrideEn,
  output logic [STRIDE_WIDTH-1:0]      lookupStride,
  output logic [MAP_WIDTH-1:0]         lookupPortionMap,
  // Current selectors, for observation
  output logic [SEL_WIDTH-1:0]         secureSelect,
  output logic [SEL_WIDTH-1:0]         nonsecureSelect
);

  localparam int IDX_W = $clog2(NUM_ENTRIES);

  // Decode byte offset to register target
  function automatic reg_sel_t decodeReg(input logic [15:0] addr);
    case (addr)
      PORTION_WIDTH_OFF: decodeReg = REG_WIDTH;
      PART_SELECT_OFF:   decodeReg = REG_SELECT;
      BW_STRIDE_OFF:     decodeReg = REG_STRIDE;
      PORTION_MAP_OFF:   decodeReg = REG_MAP;
      default:           decodeReg = REG_NONE;
    endcase
  endfunction

  // Selector in range of stored entries
  function automatic logic inRange(input logic [SEL_WIDTH-1:0] sel);
    inRange = ({16'h0000, sel} < 32'(NUM_ENTRIES));
  endfunction

  // Entry arrays, one per security state
  part_entry_t secTable_q [NUM_ENTRIES];   // Secure entries
  part_entry_t nsTable_q  [NUM_ENTRIES];   // Nonsecure entries
  logic [SEL_WIDTH-1:0] secSel_q;          // Secure selector copy
  logic [SEL_WIDTH-1:0] nsSel_q;           // Nonsecure selector copy
  logic                 pready_q;          // Access phase answer
  logic [31:0]          prdata_q;          // Registered read data
  logic                 pslverr_q;         // Registered error
  logic                 lkEn_q;            // Lookup enable result
  logic [STRIDE_WIDTH-1:0] lkStride_q;     // Lookup stride result
  logic [MAP_WIDTH-1:0]    lkMap_q;        // Lookup map result

  // Combinational decode of the current request
  reg_sel_t             target;            // Addressed register
  logic                 nonsec;            // Access security state
  logic [SEL_WIDTH-1:0] curSel;            // Selector for this state
  logic                 selOk;             // Selector has an entry
  logic [IDX_W-1:0]     curIdx;            // Entry index
  part_entry_t          curEntry;          // Addressed entry
  logic                 accessCycle;       // Access phase, answering
  logic                 doWrite;           // Write takes effect now
  logic [31:0]          readWord;          // Word to return

  always_comb begin
    target      = decodeReg(apbReq.paddr);
    nonsec      = apbReq.pprot1;
    // Bank picked by security state of the access
    curSel      = nonsec ? nsSel_q : secSel_q;
    selOk       = inRange(curSel);
    curIdx      = curSel[IDX_W-1:0];
    curEntry    = nonsec ? nsTable_q[curIdx] : secTable_q[curIdx];
    accessCycle = apbReq.psel && apbReq.penable && !pready_q;
    doWrite     = accessCycle && apbReq.pwrite;
  end

  // Read mux; reserved bits and bit 16 read zero
  always_comb begin
    readWord = 32'h0000_0000;
    case (target)
      REG_WIDTH: begin
        // Fixed width report
        readWord[15:0] = MAP_WD_VALUE;
      end
      REG_SELECT: begin
        // Internal flag is never set
        readWord[SEL_WIDTH-1:0] = curSel;
      end
      REG_STRIDE: begin
        if (selOk) begin
          readWord[STRIDE_EN_BIT]       = curEntry.strideEn;
          readWord[STRIDE_WIDTH-1:0]    = curEntry.strideMinusOne;
        end
      end
      REG_MAP: begin
        if (selOk) begin
          readWord[MAP_WIDTH-1:0] = curEntry.portionMap;
        end
      end
      default: begin
        readWord = 32'h0000_0000;
      end
    endcase
  end

  // Selector copies; a write reaches only its own state's copy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      secSel_q <= SEL_RESET;
      nsSel_q  <= SEL_RESET;
    end else if (doWrite && target == REG_SELECT) begin
      // Bits above the selector are dropped
      if (nonsec) begin
        nsSel_q <= apbReq.pwdata[SEL_WIDTH-1:0];
      end else begin
        secSel_q <= apbReq.pwdata[SEL_WIDTH-1:0];
      end
    end
  end

  // Entry tables; software is expected to set the selector first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        // Every portion open, regulation off after reset
        secTable_q[i] <= '{EN_RESET, STRIDE_RESET, MAP_RESET};
        nsTable_q[i]  <= '{EN_RESET, STRIDE_RESET, MAP_RESET};
      end
    end else if (doWrite && selOk) begin
      if (target == REG_STRIDE) begin
        // Separate stride copies per state
        if (nonsec) begin
          nsTable_q[curIdx].strideEn <= apbReq.pwdata[STRIDE_EN_BIT];
          nsTable_q[curIdx].strideMinusOne <=
            apbReq.pwdata[STRIDE_WIDTH-1:0];
        end else begin
          secTable_q[curIdx].strideEn <= apbReq.pwdata[STRIDE_EN_BIT];
          secTable_q[curIdx].strideMinusOne <=
            apbReq.pwdata[STRIDE_WIDTH-1:0];
        end
      end else if (target == REG_MAP) begin
        // Separate portion maps per state; upper bits ignored
        if (nonsec) begin
          nsTable_q[curIdx].portionMap <= apbReq.pwdata[MAP_WIDTH-1:0];
        end else begin
          secTable_q[curIdx].portionMap <= apbReq.pwdata[MAP_WIDTH-1:0];
        end
      end
    end
  end

  // APB answer: one wait state, ready in the second access cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (accessCycle) begin
      pready_q  <= 1'b1;
      prdata_q  <= apbReq.pwrite ? 32'h0000_0000 : readWord;
      // Unmapped offsets read zero, ignore writes, and flag an error
      pslverr_q <= (target == REG_NONE);
    end else begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  // Lookup for the regulators, registered one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lkEn_q     <= EN_RESET;
      lkStride_q <= STRIDE_RESET;
      lkMap_q    <= MAP_RESET;
    end else if (inRange(lookupPartition)) begin
      if (lookupNonsecure) begin
        lkEn_q     <= nsTable_q[lookupPartition[IDX_W-1:0]].strideEn;
        lkStride_q <= nsTable_q[lookupPartition[IDX_W-1:0]].strideMinusOne;
        lkMap_q    <= nsTable_q[lookupPartition[IDX_W-1:0]].portionMap;
      end else begin
        lkEn_q     <= secTable_q[lookupPartition[IDX_W-1:0]].strideEn;
        lkStride_q <= secTable_q[lookupPartition[IDX_W-1:0]].strideMinusOne;
        lkMap_q    <= secTable_q[lookupPartition[IDX_W-1:0]].portionMap;
      end
    end else begin
      // Unknown partitions: unregulated, full access
      lkEn_q     <= EN_RESET;
      lkStride_q <= STRIDE_RESET;
      lkMap_q    <= MAP_RESET;
    end
  end

  // Stride is a cost: 0 is the largest share, applied downstream
  assign lookupStrideEn   = lkEn_q;
  assign lookupStride     = lkStride_q;
  assign lookupPortionMap = lkMap_q;
  assign secureSelect     = secSel_q;
  assign nonsecureSelect  = nsSel_q;
  assign pready           = pready_q;
  assign prdata           = prdata_q;
  assign pslverr          = pslverr_q;

endmodule // partition_resource_config
